// ---- hw/scf_pkg.sv ----
// Purpose: Shared constants and types for the switcher clock and fault control
// Assumes: mclk_i at 25 MHz, registers over classic Wishbone
// Notes: Operation
package scf_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned NCH = 4;
    // ************************************************************
    // Times and derived cycle counts
    // ************************************************************
    localparam int unsigned DEGLITCH_NS = 55000;
    localparam int unsigned DEGLITCH_CYC = DEGLITCH_NS / 40;
    localparam int unsigned BLANK_US = 100;
    localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1000000);
    localparam int unsigned LSON_NS = 200;
    localparam int unsigned LSON_CYC = (LSON_NS + 39) / 40;
    localparam int unsigned OCOFF_MS = 20;
    localparam int unsigned OCOFF_CYC = OCOFF_MS * (CLK_HZ / 1000);
    localparam int unsigned DRAIN_US = 1100;
    localparam int unsigned DRAIN_CYC = DRAIN_US * (CLK_HZ / 1000000);
    localparam int unsigned SEQOFF_MS = 500;
    localparam int unsigned SEQOFF_CYC = SEQOFF_MS * (CLK_HZ / 1000);
    localparam int unsigned PROBE_CYC = 64;
    localparam int unsigned SYNC_LOCK_EDGES = 50;
    localparam int unsigned OC_TRIP = 256;
    localparam int unsigned LS_CLEAR = 6;
    // ************************************************************
    // Register map (word byte addresses)
    // ************************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FREQ = 8'h04;
    localparam logic [7:0] A_ILIM = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_FLT = 8'h10;
    localparam logic [7:0] A_REF = 8'h14;
    localparam logic [7:0] FREQ_RST = 8'h00;
    localparam logic [11:0] ILIM_RST = 12'h6e4;
    localparam logic [1:0] PH_0 = 2'h0;
    localparam logic [1:0] PH_180 = 2'h2;
    typedef enum logic [2:0] {CH_OFF, CH_SOFT, CH_RUN, CH_OVP, CH_LSON, CH_SHUT} scf_ch_e;
    typedef struct packed {
        logic ov;
        logic uv;
        logic hs_oc;
        logic ls_oc;
        logic ss_done;
        logic ramp;
    } scf_sense_s;
    typedef struct packed {
        logic hs_on;
        logic ls_on;
        logic power_good_output;
        logic amp_pull_low;
        logic ss_drain;
        logic shut;
    } scf_drive_s;
endpackage

// ---- hw/scf_sync2.sv ----
// Purpose: Two-flop synchroniser for pins
// Assumes: Width set by parameter
// Notes: First stage read only by second
`timescale 1ns/1ps
`default_nettype none
module scf_sync2 #(parameter int W = 1) (
    input wire logic mclk_i,          // Clock
    input wire logic reset_n_i,       // Async reset
    input wire logic [W-1:0] d_i,     // Async input
    output logic [W-1:0] q_o          // Synchronised
);
    logic [W-1:0] s1_r;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_r <= '0;
            q_o <= '0;
        end else begin
            s1_r <= d_i;
            q_o <= s1_r;
        end
    end
endmodule
`default_nettype wire

// ---- hw/scf_channel.sv ----
// Purpose: One buck channel fault and gate sequencing
// Assumes: Sense inputs already synchronised
// Notes: Pair coupling done by the top
`timescale 1ns/1ps
`default_nettype none
module scf_channel
    import scf_pkg::*;
#(
    parameter int unsigned OCOFF = OCOFF_CYC,
    parameter int unsigned DRAIN = DRAIN_CYC
) (
    input wire logic mclk_i,               // Clock
    input wire logic reset_n_i,            // Async reset
    input wire logic en_i,                 // Channel enabled
    input wire logic tick_i,               // PWM cycle start
    input wire logic force_shut_i,         // Partner overcurrent shutdown
    input wire scf_pkg::scf_sense_s sns_i, // Sense inputs
    output scf_pkg::scf_drive_s drv_o,     // Gate and status outputs
    output logic ocp_trip_o,               // Pulse: overcurrent shutdown start
    output logic [2:0] flags_o             // Sticky-free live ov, uv, oc
);
    import scf_pkg::*;
    typedef struct packed {
        scf_ch_e st;
        logic [12:0] ovc;
        logic [12:0] uvc;
        logic ovq;
        logic uvq;
        logic [11:0] blk;
        logic [19:0] tmr;
        logic [8:0] occ;
        logic [8:0] lsc;
        logic [2:0] lsq;
        logic ls_seen;
        logic skip;
        logic hs;
        logic ls;
    } scf_chst_s;
    scf_chst_s s_r, s_nxt;
    logic oc_hit;

    // Kept free of force_shut_i so the pair coupling has no loop
    assign oc_hit = (s_r.occ > 9'(OC_TRIP)) || (s_r.lsc == 9'(OC_TRIP));

    always_comb begin
        logic armed;
        armed = 1'b0;
        s_nxt = s_r;
        armed = (s_r.st != CH_SOFT) && (s_r.st != CH_OFF) && !sns_i.ramp && (s_r.blk == '0);
        // Blanking through a ramp and after it
        if (sns_i.ramp)
            s_nxt.blk = 12'(BLANK_CYC);
        else if (s_r.blk != '0)
            s_nxt.blk = s_r.blk - 12'h001;
        // Deglitch counters
        s_nxt.ovc = (armed && sns_i.ov) ? ((s_r.ovc == 13'(DEGLITCH_CYC)) ? s_r.ovc : s_r.ovc + 13'h1) : 13'h0;
        s_nxt.uvc = (armed && sns_i.uv) ? ((s_r.uvc == 13'(DEGLITCH_CYC)) ? s_r.uvc : s_r.uvc + 13'h1) : 13'h0;
        s_nxt.ovq = (s_nxt.ovc == 13'(DEGLITCH_CYC));
        s_nxt.uvq = (s_nxt.uvc == 13'(DEGLITCH_CYC));
        if (tick_i) begin
            // Per-cycle peak and low-side counting
            s_nxt.skip = sns_i.hs_oc;
            if (sns_i.hs_oc && armed)
                s_nxt.occ = s_r.occ + 9'h1;
            else
                s_nxt.occ = 9'h0;
            s_nxt.lsq = s_r.ls_seen ? 3'h0 : ((s_r.lsq == 3'(LS_CLEAR)) ? s_r.lsq : s_r.lsq + 3'h1);
            if (!s_r.ls_seen && s_r.lsq == 3'(LS_CLEAR - 1))
                s_nxt.lsc = 9'h0;
            s_nxt.ls_seen = 1'b0;
        end
        if (sns_i.ls_oc && !s_r.ls_seen && armed) begin
            s_nxt.ls_seen = 1'b1;
            s_nxt.lsc = s_r.lsc + 9'h1;
        end
        // Gate drive defaults: CCM, high side at cycle start
        if (tick_i)
            s_nxt.hs = !sns_i.hs_oc;
        s_nxt.ls = 1'b0;
        if (sns_i.hs_oc || s_r.skip) begin
            s_nxt.hs = 1'b0;
        end
        if (sns_i.ls_oc) begin
            s_nxt.hs = 1'b0;
            s_nxt.ls = 1'b1;
        end else if (!s_nxt.hs && !s_r.skip && !sns_i.hs_oc && s_r.hs == 1'b0 && !tick_i) begin
            s_nxt.ls = s_r.ls;
        end
        case (s_r.st)
            CH_OFF: begin
                s_nxt.hs = 1'b0;
                s_nxt.ls = 1'b0;
                s_nxt.occ = 9'h0;
                s_nxt.lsc = 9'h0;
                if (en_i && !force_shut_i)
                    s_nxt.st = CH_SOFT;
            end
            CH_SOFT: begin
                s_nxt.ovc = 13'h0;
                s_nxt.uvc = 13'h0;
                s_nxt.occ = 9'h0;
                s_nxt.lsc = 9'h0;
                if (sns_i.ss_done)
                    s_nxt.st = CH_RUN;
            end
            CH_RUN: begin
                if (s_nxt.ovq) begin
                    s_nxt.st = CH_OVP;
                end else if (oc_hit) begin
                    s_nxt.st = CH_SHUT;
                    s_nxt.tmr = 20'(OCOFF);
                end
            end
            CH_OVP: begin
                s_nxt.hs = 1'b0;
                s_nxt.ls = 1'b0;
                if (!sns_i.ov) begin
                    s_nxt.st = CH_LSON;
                    s_nxt.tmr = 20'(LSON_CYC);
                end
            end
            CH_LSON: begin
                s_nxt.hs = 1'b0;
                s_nxt.ls = 1'b1;
                s_nxt.tmr = s_r.tmr - 20'h1;
                if (s_r.tmr == 20'h1)
                    s_nxt.st = CH_RUN;
            end
            CH_SHUT: begin
                s_nxt.hs = 1'b0;
                s_nxt.ls = 1'b0;
                s_nxt.occ = 9'h0;
                s_nxt.lsc = 9'h0;
                if (s_r.tmr != 20'h0)
                    s_nxt.tmr = s_r.tmr - 20'h1;
                else
                    s_nxt.st = CH_OFF;
            end
            default: s_nxt.st = CH_OFF;
        endcase
        if (force_shut_i && s_r.st != CH_SHUT) begin
            s_nxt.st = CH_SHUT;
            s_nxt.tmr = 20'(OCOFF);
            s_nxt.hs = 1'b0;
            s_nxt.ls = 1'b0;
        end
        if (!en_i && s_r.st != CH_SHUT) begin
            s_nxt.st = CH_OFF;
            s_nxt.hs = 1'b0;
            s_nxt.ls = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            s_r <= '{st: CH_OFF, default: '0};
        else
            s_r <= s_nxt;
    end

    always_comb begin
        drv_o.hs_on = s_r.hs;
        drv_o.ls_on = s_r.ls;
        drv_o.power_good_output = (s_r.st == CH_RUN || s_r.st == CH_LSON) && !s_r.uvq;
        drv_o.shut = (s_r.st == CH_SHUT);
        // Drain during the last stretch of the off time
        drv_o.amp_pull_low = (s_r.st == CH_SHUT) && (s_r.tmr < 20'(DRAIN));
        drv_o.ss_drain = (s_r.st == CH_SHUT) && (s_r.tmr < 20'(DRAIN));
    end
    assign ocp_trip_o = (s_r.st == CH_RUN) && en_i && !s_nxt.ovq && oc_hit;
    assign flags_o = {s_r.ovq, s_r.uvq, s_r.skip};
endmodule
`default_nettype wire

// ---- hw/scf_top.sv ----
// Purpose: PWM clocks and fault control for four buck channels
// Assumes: Classic Wishbone slave, one clock
// Notes: Sync edge and sense pins pass two flops
`timescale 1ns/1ps
`default_nettype none
module scf_top
    import scf_pkg::*;
#(
    parameter int unsigned OCOFF = OCOFF_CYC,
    parameter int unsigned DRAIN = DRAIN_CYC,
    parameter int unsigned SEQOFF = SEQOFF_CYC,
    parameter int unsigned BASE_DIV = 8
) (
    input wire logic mclk_i,                       // 25 MHz clock
    input wire logic reset_n_i,                    // Async reset, low
    input wire logic wb_cyc_i,                     // Wishbone cycle
    input wire logic wb_stb_i,                     // Wishbone strobe
    input wire logic wb_we_i,                      // Write enable
    input wire logic [7:0] wb_adr_i,               // Byte address
    input wire logic [3:0] wb_sel_i,               // Byte lanes
    input wire logic [31:0] wb_dat_i,              // Write data
    output logic [31:0] wb_dat_o,                  // Read data
    output logic wb_ack_o,                         // Acknowledge
    output logic wb_err_o,                         // Unmapped address
    input wire logic sync_pin_i,                   // External sync pulses
    input wire logic [3:0] switcher_enable_pin_i,  // Channel enables
    input wire logic [1:0] share_probe_i,          // Slave amp node high
    output logic [1:0] share_probe_pull_o,         // Discharge during probe
    input wire logic over_temp_i,                  // Above hysteresis
    input wire scf_pkg::scf_sense_s [3:0] sense_i, // Per-channel sense
    output scf_pkg::scf_drive_s [3:0] drive_o,     // Per-channel drive
    output logic [3:0] pwm_clk_o,                  // Per-channel PWM clocks
    output logic master_clk_o,                     // Master clock out
    output logic sync_locked_o                     // Locked to sync
);
    import scf_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] freq;
        logic [11:0] ilim;
        logic [3:0] en;
        logic intseq;
        logic [1:0] share;
        logic [6:0] probe;
        logic startup;
        logic [23:0] seqoff;
        logic [3:0] ramp_req;
        logic [4:0] mdiv;
        logic [4:0] period;
        logic [4:0] scnt;
        logic [5:0] edges;
        logic locked;
        logic sync_d;
        logic [2:0] ph;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic [3:0] trip_st;
    } scf_top_s;
    scf_top_s s_r, s_nxt;

    logic sync_s;
    logic [3:0] ens_s;
    logic [1:0] probe_s;
    logic otp_s;
    logic [3:0] tick;
    logic [3:0] ocp_trip;
    logic [3:0] shut;
    logic [11:0] ch_flags;
    scf_drive_s [3:0] drv;
    scf_sense_s [3:0] sense_s;

    scf_sync2 #(.W(24)) u_sns (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .d_i(sense_i),
        .q_o(sense_s)
    );

    scf_sync2 #(.W(8)) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .d_i({sync_pin_i, switcher_enable_pin_i, share_probe_i, over_temp_i}),
        .q_o({sync_s, ens_s, probe_s, otp_s})
    );

    // Divider code to mask of phase counter bits
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        div_mask = 3'((4'h1 << code) - 4'h1);
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic hit;
        hit = 1'b0;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.ramp_req = 4'h0;
        // Master clock: free run at BASE_DIV, retimed to sync edges
        s_nxt.sync_d = sync_s;
        s_nxt.scnt = (s_r.scnt == 5'h1f) ? s_r.scnt : s_r.scnt + 5'h1;
        if (sync_s && !s_r.sync_d) begin
            s_nxt.scnt = 5'h0;
            if (s_r.startup == 1'b0 && s_r.scnt < 5'h1f) begin
                s_nxt.period = s_r.scnt + 5'h1;
                if (s_r.edges != 6'(SYNC_LOCK_EDGES))
                    s_nxt.edges = s_r.edges + 6'h1;
            end
        end
        if (s_r.scnt == 5'h1f) begin
            s_nxt.edges = 6'h0;
            s_nxt.period = 5'(BASE_DIV);
        end
        s_nxt.locked = (s_nxt.edges == 6'(SYNC_LOCK_EDGES));
        hit = (s_r.mdiv + 5'h1 >= s_r.period) || (s_r.locked && sync_s && !s_r.sync_d);
        s_nxt.mdiv = hit ? 5'h0 : s_r.mdiv + 5'h1;
        if (hit)
            s_nxt.ph = s_r.ph + 3'h1;
        // Sharing probe after reset
        if (s_r.probe != 7'(PROBE_CYC)) begin
            s_nxt.probe = s_r.probe + 7'h1;
            if (s_r.probe == 7'(PROBE_CYC - 1))
                s_nxt.share = probe_s;
        end
        // Startup fault hold-off and overtemperature
        if (s_r.seqoff != 24'h0)
            s_nxt.seqoff = s_r.seqoff - 24'h1;
        if (s_r.intseq && s_r.startup && (|ocp_trip || |s_r.trip_st))
            s_nxt.seqoff = 24'(SEQOFF);
        if (&(s_r.en & ens_s) || !s_r.intseq)
            s_nxt.startup = 1'b0;
        s_nxt.trip_st = {ch_flags[11], ch_flags[8], ch_flags[5], ch_flags[2]};
        if (otp_s)
            s_nxt.startup = 1'b1;
        // Register access
        if (wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err) begin
            s_nxt.ack = 1'b1;
            case (wb_adr_i)
                A_CTRL: begin
                    s_nxt.rdat = {27'h0, s_r.intseq, s_r.en};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.en = wb_dat_i[3:0];
                        s_nxt.intseq = wb_dat_i[4];
                    end
                end
                A_FREQ: begin
                    s_nxt.rdat = {24'h0, s_r.freq};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.freq[1:0] = wb_dat_i[1:0];
                        s_nxt.freq[5:4] = wb_dat_i[5:4];
                        // Slave divider bits refused while its pair shares
                        if (!s_r.share[0]) s_nxt.freq[3:2] = wb_dat_i[3:2];
                        if (!s_r.share[1]) s_nxt.freq[7:6] = wb_dat_i[7:6];
                    end
                end
                A_ILIM: begin
                    s_nxt.rdat = {20'h0, s_r.ilim};
                    if (wb_we_i && wb_sel_i[0])
                        s_nxt.ilim[7:0] = wb_dat_i[7:0];
                    if (wb_we_i && wb_sel_i[1])
                        s_nxt.ilim[11:8] = wb_dat_i[11:8];
                end
                A_STAT: s_nxt.rdat = {13'h0, s_r.locked, s_r.share, shut, ch_flags};
                A_FLT: s_nxt.rdat = {7'h0, s_r.seqoff, s_r.startup};
                A_REF: begin
                    s_nxt.rdat = 32'h0;
                    if (wb_we_i && wb_sel_i[0])
                        s_nxt.ramp_req = wb_dat_i[3:0];
                end
                default: begin
                    s_nxt.ack = 1'b0;
                    s_nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            s_r <= '{freq: FREQ_RST, ilim: ILIM_RST, startup: 1'b1, period: 5'(BASE_DIV),
                     default: '0};
        else
            s_r <= s_nxt;
    end

    // ************************************************************
    // Per-channel clocks and fault logic
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            localparam int M = (g / 2) * 2;
            logic slave;
            logic [1:0] dv;
            logic [1:0] phs;
            logic [2:0] pc;
            scf_sense_s sn;
            assign slave = (g % 2 == 1) && s_r.share[g / 2];
            // Slave follows master divider, phase + 180 at divide by 8 only, else in phase
            assign dv = slave ? s_r.freq[2*M +: 2] : s_r.freq[2*g +: 2];
            assign phs = slave ? (2'(M / 2) ^ PH_180) : 2'(g == 0 ? 0 : g == 1 ? 2 : g == 2 ? 1 : 3);
            assign pc = s_r.ph + {phs, 1'b0};
            assign tick[g] = ((pc & div_mask(dv)) == 3'h0) && (s_r.mdiv == 5'h0);
            // Divide by one has no phase bits, so it is the master clock
            assign pwm_clk_o[g] = (dv == 2'h0) ? master_clk_o :
                ((pc & div_mask(dv)) <= (div_mask(dv) >> 1));
            assign sn = sense_s[g];
            scf_channel #(.OCOFF(OCOFF), .DRAIN(DRAIN)) u_ch (
                .mclk_i(mclk_i),
                .reset_n_i(reset_n_i),
                .en_i(s_r.en[g] & ens_s[g] & (s_r.seqoff == 24'h0) & !otp_s),
                .tick_i(tick[g]),
                .force_shut_i(s_r.share[g / 2] & ocp_trip[g ^ 1]),
                .sns_i(sn),
                .drv_o(drv[g]),
                .ocp_trip_o(ocp_trip[g]),
                .flags_o(ch_flags[3*g +: 3])
            );
            assign shut[g] = drv[g].shut;
        end
    endgenerate

    assign drive_o = drv;
    assign master_clk_o = (s_r.mdiv < (s_r.period >> 1));
    assign sync_locked_o = s_r.locked;
    assign share_probe_pull_o = (s_r.probe != 7'(PROBE_CYC)) ? 2'h3 : 2'h0;
    assign wb_ack_o = s_r.ack;
    assign wb_err_o = s_r.err;
    assign wb_dat_o = s_r.rdat;
endmodule
`default_nettype wire

// ---- verif/scf_stage_model.sv ----
// Purpose: Behavioural power stage feeding channel sense
// Assumes: Bench commands the fault levels
// Notes: Soft-start ends 16 cycles after release
`timescale 1ns/1ps
`default_nettype none
module scf_stage_model (
    input wire logic mclk_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire scf_pkg::scf_drive_s [3:0] drive_i, // Gate drive
    input wire logic [3:0] en_i, // Channel enables
    input wire logic [15:0] flt_i, // ov,uv,hs,ls per channel
    output scf_pkg::scf_sense_s [3:0] sense_o // Sense back
);
    import scf_pkg::*;
    logic [3:0][4:0] ss_r;
    // ****
    // Soft-start ramp, drained on shutdown
    // ****
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!reset_n_i || !en_i[i] || drive_i[i].shut || drive_i[i].ss_drain) begin
                ss_r[i] <= 5'h00;
            end else if (!ss_r[i][4]) begin
                ss_r[i] <= ss_r[i] + 5'h01;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sense_o[i] = {flt_i[4*i+:4], ss_r[i][4], 1'b0};
        end
    end
endmodule
`default_nettype wire

// ---- verif/scf_chk.sv ----
// Purpose: Port checker for scf_top
// Assumes: One clock, async low reset
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module scf_chk (
    input wire logic mclk_i, // Clock
    input wire logic reset_n_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Ack
    input wire logic wb_err_o, // Error
    input wire logic sync_pin_i, // Sync pulses
    input wire logic over_temp_i, // Hot
    input wire scf_pkg::scf_sense_s [3:0] sense_i, // Sense
    input wire scf_pkg::scf_drive_s [3:0] drive_o, // Drive
    input wire logic [1:0] share_probe_pull_o, // Probe pull
    input wire logic sync_locked_o // Locked
);
    import scf_pkg::*;
    logic [7:0] rc_r, ec_r, gap_r;
    logic sp_r;
    // ****
    // Helper counters
    // ****
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rc_r <= 8'h00;
            ec_r <= 8'h00;
            gap_r <= 8'h00;
            sp_r <= 1'b0;
        end else begin
            sp_r <= sync_pin_i;
            if (rc_r != 8'hff) rc_r <= rc_r + 8'h01;
            if (sync_pin_i && !sp_r && ec_r != 8'hff) ec_r <= ec_r + 8'h01;
            if (sync_pin_i && !sp_r) gap_r <= 8'h00;
            else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_hot;
        over_temp_i [*4];
    endsequence
    AST_ANSWER: assert property (s_taken |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered once");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ERR_ONE: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
    AST_GATES: assert property (!(drive_o[0].hs_on && drive_o[0].ls_on))
        else $error("both gates on");
    AST_HOT: assert property (s_hot |=> !(drive_o[0].hs_on | drive_o[1].hs_on |
        drive_o[2].hs_on | drive_o[3].hs_on)) else $error("switching while hot");
    AST_HSOC: assert property (sense_i[0].hs_oc [*4] |=> !drive_o[0].hs_on)
        else $error("high side on at peak limit");
    AST_LSOC: assert property (sense_i[0].ls_oc [*4] |=> !drive_o[0].hs_on)
        else $error("high side on at low side limit");
    AST_SHUT: assert property (drive_o[0].shut |-> !drive_o[0].hs_on && !drive_o[0].ls_on)
        else $error("gates on in shutdown");
    AST_PROBE: assert property (rc_r > 8'h01 && rc_r < 8'h3c |-> share_probe_pull_o == 2'b11)
        else $error("probe pull missing");
    AST_LOCK: assert property ($rose(sync_locked_o) |-> ec_r >= 8'h32)
        else $error("lock too early");
    AST_LOSS: assert property (gap_r > 8'h30 |-> !sync_locked_o)
        else $error("lock kept without sync");
endmodule
bind scf_top scf_chk i_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .sync_pin_i(sync_pin_i), .over_temp_i(over_temp_i), .sense_i(sense_i),
    .drive_o(drive_o), .share_probe_pull_o(share_probe_pull_o), .sync_locked_o(sync_locked_o));
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for scf_top
// Assumes: Shortened shutdown counts
// Notes: Reads are noted in a queue
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scf_pkg::*;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic sync_pin_i = 1'b0, over_temp_i = 1'b0, wb_ack_o, wb_err_o, sync_locked_o, mco;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf, en = 4'h0, pwm;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rs = 32'ha3b7;
    logic [15:0] flt = 16'h0;
    logic [1:0] pull, probe = 2'b00;
    logic [63:0] q[$];
    scf_sense_s [3:0] sense;
    scf_drive_s [3:0] drive;
    int n_tests = 0, n_fail = 0, cyc_n = 0;
    scf_top #(.OCOFF(200), .DRAIN(50), .SEQOFF(300)) i_dut (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sync_pin_i(sync_pin_i),
        .switcher_enable_pin_i(en), .share_probe_i(probe), .share_probe_pull_o(pull),
        .over_temp_i(over_temp_i), .sense_i(sense), .drive_o(drive), .pwm_clk_o(pwm),
        .master_clk_o(mco), .sync_locked_o(sync_locked_o));
    scf_stage_model i_stage (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .drive_i(drive),
        .en_i(en), .flt_i(flt), .sense_o(sense));
    // ****
    // Helpers
    // ****
    initial forever #20 mclk_i = ~mclk_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic e);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        logic e;
        q.push_back({m, x});
        wb(1'b0, a, 32'h0, e);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        logic [63:0] nt;
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            wrap_up();
        end else if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
            nt = q.pop_front();
            check(wb_dat_o & nt[63:32], nt[31:0]);
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        logic e;
        int k, n;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        check(32'(pull), 32'h3);
        repeat (70) @(posedge mclk_i);
        rd(A_FREQ, 32'(FREQ_RST), 32'hff);
        rd(A_ILIM, 32'(ILIM_RST), 32'hfff);
        rd(A_STAT, 32'h0, 32'h30000);
        wb(1'b0, 8'hfc, 32'h0, e);
        check(32'(e), 32'h1);
        $display("test reset values done");
        rs = xs(rs);
        wb(1'b1, A_ILIM, rs, e);
        rd(A_ILIM, rs & 32'hfff, 32'hfff);
        rs = xs(rs);
        wb(1'b1, A_FREQ, rs, e);
        rd(A_FREQ, rs & 32'hff, 32'hff);
        for (k = 3; k >= 0; k--) begin
            wb(1'b1, A_FREQ, 32'({4{k[1:0]}}), e);
            rd(A_FREQ, 32'({4{k[1:0]}}), 32'hff);
            e = pwm[3];
            n = 0;
            repeat (64) begin
                @(posedge mclk_i);
                if (pwm[3] && !e) n++;
                e = pwm[3];
            end
            check(n, 32'(8 >> k));
        end
        $display("test dividers done");
        wb(1'b1, A_CTRL, 32'h0f, e);
        en <= 4'hf;
        repeat (60) begin
            sync_pin_i <= 1'b1;
            repeat (3) @(posedge mclk_i);
            sync_pin_i <= 1'b0;
            repeat (3) @(posedge mclk_i);
        end
        check(32'(sync_locked_o), 32'h1);
        rd(A_STAT, 32'h40000, 32'h40000);
        repeat (50) @(posedge mclk_i);
        check(32'(sync_locked_o), 32'h0);
        $display("test sync done");
        flt <= 16'h0001;
        repeat (8) @(posedge mclk_i);
        check(32'(drive[0].hs_on), 32'h0);
        flt <= 16'h0002;
        k = 0;
        while (drive[0].shut !== 1'b1 && k < 4000) begin
            @(posedge mclk_i);
            k++;
        end
        check(32'(drive[0].shut), 32'h1);
        check(32'(drive[1].shut), 32'h0);
        flt <= 16'h0;
        $display("test overcurrent done");
        over_temp_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        check(32'({drive[3].hs_on, drive[2].hs_on, drive[1].hs_on, drive[0].hs_on}), 32'h0);
        over_temp_i <= 1'b0;
        repeat (40) @(posedge mclk_i);
        $display("test overtemperature done");
        probe <= 2'b01;
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (80) @(posedge mclk_i);
        rd(A_STAT, 32'h10000, 32'h30000);
        wb(1'b1, A_FREQ, 32'hff, e);
        rd(A_FREQ, 32'hf3, 32'hff);
        $display("test sharing done");
        wrap_up();
    end
endmodule
`default_nettype wire
